/* File: logic/osbp_pkg.sv */
// Function
// - after reset fetch starts at word 0x0000; interrupt entry fetches from 0x0004
// - programming only clears ones to zeros; a zero bit never returns to one; this model blanks every word on reset
// - blank words read all ones; an all-zero word decodes as no-operation
// - large parts combine the page-select latch with each relocated jump target
// - every reset starts the resident boot sequence before application code
// - boot sets fixed baud, sends a request; host answers with acknowledgment
// - host then sends address and data bytes; device programs data at address
// - each pair loads 16-bit pointer and 16-bit data latch
// - voltage-enable output driven low before the write
// - a table write starts a long write halting execution until it ends
// - the long write holds voltage-enable low for PULSE_CYC+1 cycles, one clock over the 1 ms maximum pulse width
// - after writing, voltage-enable goes high, then the word is read back
// - matching read-back sends acknowledge; sequence repeats for every location
// - no host answer abandons boot and starts normal execution
// - dedicated table write, table read and latch access operations exist
// - read-back mismatch reports a programming error instead of acknowledge
// - acknowledgment is awaited only until a time-out, then application runs
package osbp_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ        = 250_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int BAUD          = 115_200;
    localparam int BIT_CYC       = CLK_HZ / BAUD;
    localparam int CHAR_BITS     = 10;
    localparam int TIMEOUT_CHARS = 8;
    localparam int TIMEOUT_CYC   = BIT_CYC * CHAR_BITS * TIMEOUT_CHARS;
    localparam int PULSE_MAX_NS  = 1_000_000;
    localparam int PULSE_CYC     = PULSE_MAX_NS / CLK_PERIOD_NS;
    // ---------------------------------------------------------------
    // memory and vectors
    // ---------------------------------------------------------------
    localparam logic [15:0] RESET_VEC  = 16'h0000;
    localparam logic [15:0] INT_VEC    = 16'h0004;
    localparam int          WORD_W     = 14;
    localparam int          MEM_AW     = 11;
    localparam int          PAGE_WORDS = 2048;
    localparam int          JUMP_W     = 11;
    localparam int          FIFO_W     = 8;
    localparam int          FIFO_D     = 8;
    // ---------------------------------------------------------------
    // serial protocol bytes
    // ---------------------------------------------------------------
    localparam logic [7:0] REQ_BYTE  = 8'hA5;
    localparam logic [7:0] HOST_ACK  = 8'h5A;
    localparam logic [7:0] DEV_ACK   = 8'h06;
    localparam logic [7:0] DEV_ERR   = 8'h15;

    typedef enum logic [3:0] {
        ST_REQ     = 4'h0,
        ST_WAIT    = 4'h1,
        ST_GET     = 4'h2,
        ST_VPP_ON  = 4'h3,
        ST_WRITE   = 4'h4,
        ST_PULSE   = 4'h5,
        ST_VPP_OFF = 4'h6,
        ST_RD      = 4'h7,
        ST_CMP     = 4'h8,
        ST_RESP    = 4'h9,
        ST_RUN     = 4'hA
    } osbp_state_t;
endpackage : osbp_pkg

/* File: logic/osbp_mem_if.sv */
`timescale 1ns/1ps
interface osbp_mem_if #(
    parameter int AW = 11,
    parameter int DW = 14
);
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          we;
    logic          re;
    logic [DW-1:0] rdata;
    modport host (output addr, output wdata, output we, output re,
                  input rdata);
    modport mem  (input addr, input wdata, input we, input re,
                  output rdata);
endinterface : osbp_mem_if

/* File: logic/osbp_fifo.sv */
`timescale 1ns/1ps
module osbp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] buf_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data  = buf_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            buf_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : osbp_fifo

/* File: logic/osbp_otp_mem.sv */
`timescale 1ns/1ps
module osbp_otp_mem #(
    parameter int AW = 11,
    parameter int DW = 14
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // access port
    osbp_mem_if.mem   port
);
    localparam int N = 2 ** AW;
    logic [DW-1:0] cell_q [N];
    logic [N-1:0]  used_q;
    logic [DW-1:0] cur;

    // model only: a real cell keeps its charge, here reset blanks it
    assign cur = used_q[port.addr] ? cell_q[port.addr] : '1;

    for (genvar i = 0; i < N; i++) begin : g_used
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                used_q[i] <= 1'b0;
            end else if (port.we && port.addr == AW'(i)) begin
                used_q[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (port.we) begin
            cell_q[port.addr] <= cur & port.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port.rdata <= '1;
        end else if (port.re) begin
            port.rdata <= cur;
        end
    end
endmodule : osbp_otp_mem

/* File: logic/osbp_boot_top.sv */
`timescale 1ns/1ps
module osbp_boot_top #(
    parameter int TIMEOUT_CYC = osbp_pkg::TIMEOUT_CYC,
    parameter int PULSE_CYC   = osbp_pkg::PULSE_CYC,
    parameter int BIT_CYC     = osbp_pkg::BIT_CYC,
    parameter int MEM_AW      = osbp_pkg::MEM_AW,
    parameter int WORD_W      = osbp_pkg::WORD_W
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // serial link
    input  wire logic        rx_line,
    output logic             tx_line,
    // programming voltage
    output logic             prog_voltage_enable_n,
    // core control
    output logic             core_halt,
    output logic             vec_load,
    output logic [15:0]      vec_addr,
    input  wire logic        irq_req,
    // core table operations
    input  wire logic        table_write_instr,
    input  wire logic        table_read_instr,
    input  wire logic        latch_write_instr,
    input  wire logic        latch_read_instr,
    input  wire logic        ptr_write,
    input  wire logic [15:0] core_wdata,
    output logic [15:0]      latch_rdata,
    input  wire logic        page_write,
    input  wire logic [4:0]  page_wdata,
    // instruction fetch
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_valid,
    output logic [15:0]      fetch_word,
    output logic             fetch_nop,
    output logic [15:0]      jump_target,
    // status
    output logic             boot_active,
    output logic             prog_error,
    output logic             rx_overrun
);
    localparam int MAX_CNT = (TIMEOUT_CYC > PULSE_CYC) ?
                             TIMEOUT_CYC : PULSE_CYC;
    localparam int CW = $clog2(MAX_CNT + 1);
    localparam int BW = $clog2(BIT_CYC + 1);

    osbp_pkg::osbp_state_t st_q;
    logic [CW-1:0]  tmr_q;
    logic [15:0]    table_address_pointer_q;
    logic [15:0]    table_data_latch_q;
    logic [4:0]     page_select_latch_q;
    logic [1:0]     byte_idx_q;
    logic           boot_q;
    logic           op_rd_q;
    logic           resp_err_q;
    logic           fetch_pend_q;

    // ---------------------------------------------------------------
    // receiver and byte buffer
    // ---------------------------------------------------------------
    logic           rx_busy_q;
    logic [BW-1:0]  rx_cnt_q;
    logic [3:0]     rx_bit_q;
    logic [7:0]     rx_shift_q;
    logic           rx_valid_q;
    logic           fifo_in_ready;
    logic           fifo_out_valid;
    logic           fifo_pop;
    logic [7:0]     fifo_out_data;

    // rx line treated as synchronous to clk_sys
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_busy_q  <= 1'b0;
            rx_cnt_q   <= '0;
            rx_bit_q   <= '0;
            rx_shift_q <= '0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (!rx_busy_q) begin
                if (!rx_line) begin
                    rx_busy_q <= 1'b1;
                    rx_cnt_q  <= BW'(BIT_CYC / 2);
                    rx_bit_q  <= '0;
                end
            end else if (rx_cnt_q != '0) begin
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end else begin
                rx_cnt_q <= BW'(BIT_CYC - 1);
                rx_bit_q <= rx_bit_q + 1'b1;
                if (rx_bit_q == 4'h0 && rx_line) begin
                    rx_busy_q <= 1'b0;
                end else if (rx_bit_q == 4'h9) begin
                    rx_busy_q  <= 1'b0;
                    rx_valid_q <= rx_line;
                end else if (rx_bit_q != 4'h0) begin
                    rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                end
            end
        end
    end

    // bytes arriving while the buffer is full are lost and flagged
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_overrun <= 1'b0;
        end else if (rx_valid_q && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
        end
    end

    osbp_fifo #(
        .W (osbp_pkg::FIFO_W),
        .D (osbp_pkg::FIFO_D)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (rx_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_shift_q),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // draining stalls during the long write, so the buffer really fills
    assign fifo_pop = fifo_out_valid &&
                      (st_q == osbp_pkg::ST_WAIT || st_q == osbp_pkg::ST_GET);

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    logic           tx_go;
    logic [7:0]     tx_byte;
    logic           tx_busy_q;
    logic [9:0]     tx_shift_q;
    logic [3:0]     tx_bit_q;
    logic [BW-1:0]  tx_cnt_q;

    always_comb begin
        tx_go   = 1'b0;
        tx_byte = osbp_pkg::REQ_BYTE;
        if (!tx_busy_q && st_q == osbp_pkg::ST_REQ) begin
            tx_go = 1'b1;
        end else if (!tx_busy_q && st_q == osbp_pkg::ST_RESP) begin
            tx_go   = 1'b1;
            tx_byte = resp_err_q ? osbp_pkg::DEV_ERR
                                 : osbp_pkg::DEV_ACK;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_busy_q  <= 1'b0;
            tx_shift_q <= '1;
            tx_bit_q   <= '0;
            tx_cnt_q   <= '0;
            tx_line    <= 1'b1;
        end else if (tx_go) begin
            tx_busy_q  <= 1'b1;
            tx_shift_q <= {1'b1, tx_byte, 1'b0};
            tx_bit_q   <= '0;
            tx_cnt_q   <= BW'(BIT_CYC - 1);
            tx_line    <= 1'b0;
        end else if (tx_busy_q) begin
            if (tx_cnt_q != '0) begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end else if (tx_bit_q == 4'h9) begin
                tx_busy_q <= 1'b0;
            end else begin
                tx_cnt_q   <= BW'(BIT_CYC - 1);
                tx_bit_q   <= tx_bit_q + 1'b1;
                tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                tx_line    <= tx_shift_q[1];
            end
        end
    end

    // ---------------------------------------------------------------
    // program memory
    // ---------------------------------------------------------------
    osbp_mem_if #(.AW(MEM_AW), .DW(WORD_W)) mem_bus ();

    osbp_otp_mem #(
        .AW (MEM_AW),
        .DW (WORD_W)
    ) u_mem (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .port    (mem_bus.mem)
    );

    logic run_fetch;
    assign run_fetch = st_q == osbp_pkg::ST_RUN && fetch_req &&
                       !table_write_instr && !table_read_instr;

    always_comb begin
        mem_bus.addr  = table_address_pointer_q[MEM_AW-1:0];
        mem_bus.wdata = table_data_latch_q[WORD_W-1:0];
        mem_bus.we    = st_q == osbp_pkg::ST_WRITE;
        mem_bus.re    = st_q == osbp_pkg::ST_RD || run_fetch;
        if (run_fetch) begin
            mem_bus.addr = fetch_addr[MEM_AW-1:0];
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q       <= osbp_pkg::ST_REQ;
            tmr_q      <= '0;
            byte_idx_q <= '0;
            boot_q     <= 1'b1;
            op_rd_q    <= 1'b0;
            resp_err_q <= 1'b0;
        end else begin
            case (st_q)
                osbp_pkg::ST_REQ: begin
                    tmr_q <= '0;
                    if (tx_go) begin
                        st_q <= osbp_pkg::ST_WAIT;
                    end
                end
                osbp_pkg::ST_WAIT: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (fifo_pop &&
                        fifo_out_data == osbp_pkg::HOST_ACK) begin
                        st_q       <= osbp_pkg::ST_GET;
                        byte_idx_q <= '0;
                    end else if (tmr_q == CW'(TIMEOUT_CYC - 1)) begin
                        st_q   <= osbp_pkg::ST_RUN;
                        boot_q <= 1'b0;
                    end
                end
                osbp_pkg::ST_GET: begin
                    if (fifo_pop) begin
                        byte_idx_q <= byte_idx_q + 1'b1;
                        if (byte_idx_q == 2'd3) begin
                            st_q <= osbp_pkg::ST_VPP_ON;
                        end
                    end
                end
                osbp_pkg::ST_VPP_ON: begin
                    st_q <= osbp_pkg::ST_WRITE;
                end
                osbp_pkg::ST_WRITE: begin
                    tmr_q <= '0;
                    st_q  <= osbp_pkg::ST_PULSE;
                end
                osbp_pkg::ST_PULSE: begin
                    tmr_q <= tmr_q + 1'b1;
                    // the internal end-of-write event
                    if (tmr_q == CW'(PULSE_CYC - 2)) begin
                        st_q <= osbp_pkg::ST_VPP_OFF;
                    end
                end
                osbp_pkg::ST_VPP_OFF: begin
                    st_q <= osbp_pkg::ST_RD;
                end
                osbp_pkg::ST_RD: begin
                    st_q <= osbp_pkg::ST_CMP;
                end
                osbp_pkg::ST_CMP: begin
                    resp_err_q <= mem_bus.rdata !=
                                  table_data_latch_q[WORD_W-1:0];
                    if (boot_q) begin
                        st_q <= osbp_pkg::ST_RESP;
                    end else begin
                        st_q <= osbp_pkg::ST_RUN;
                    end
                    op_rd_q <= 1'b0;
                end
                osbp_pkg::ST_RESP: begin
                    if (tx_go) begin
                        st_q       <= osbp_pkg::ST_GET;
                        byte_idx_q <= '0;
                    end
                end
                osbp_pkg::ST_RUN: begin
                    if (table_write_instr) begin
                        st_q <= osbp_pkg::ST_VPP_ON;
                    end else if (table_read_instr) begin
                        st_q    <= osbp_pkg::ST_RD;
                        op_rd_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= osbp_pkg::ST_REQ;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pointer, latch and page select
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            table_address_pointer_q <= '0;
            table_data_latch_q      <= '0;
            latch_rdata             <= '0;
        end else if (st_q == osbp_pkg::ST_GET && fifo_pop) begin
            case (byte_idx_q)
                2'd0: table_address_pointer_q[15:8] <= fifo_out_data;
                2'd1: table_address_pointer_q[7:0]  <= fifo_out_data;
                2'd2: table_data_latch_q[15:8]      <= fifo_out_data;
                default: table_data_latch_q[7:0]    <= fifo_out_data;
            endcase
        end else if (st_q == osbp_pkg::ST_CMP && op_rd_q) begin
            table_data_latch_q <= 16'(mem_bus.rdata);
        end else if (st_q == osbp_pkg::ST_RUN) begin
            if (ptr_write) begin
                table_address_pointer_q <= core_wdata;
            end
            if (latch_write_instr) begin
                table_data_latch_q <= core_wdata;
            end
            if (latch_read_instr) begin
                latch_rdata <= table_data_latch_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            page_select_latch_q <= '0;
        end else if (page_write) begin
            page_select_latch_q <= page_wdata;
        end
    end

    // ---------------------------------------------------------------
    // voltage enable, halt and status
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prog_voltage_enable_n <= 1'b1;
        end else if (st_q == osbp_pkg::ST_VPP_ON) begin
            prog_voltage_enable_n <= 1'b0;
        end else if (st_q == osbp_pkg::ST_VPP_OFF) begin
            prog_voltage_enable_n <= 1'b1;
        end
    end

    // halted through boot and every long write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_halt   <= 1'b1;
            boot_active <= 1'b1;
            prog_error  <= 1'b0;
        end else begin
            core_halt   <= st_q != osbp_pkg::ST_RUN;
            boot_active <= boot_q;
            if (st_q == osbp_pkg::ST_CMP && !op_rd_q) begin
                prog_error <= mem_bus.rdata !=
                              table_data_latch_q[WORD_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // vectors and fetch
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vec_load <= 1'b0;
            vec_addr <= osbp_pkg::RESET_VEC;
        end else begin
            vec_load <= 1'b0;
            if (st_q == osbp_pkg::ST_WAIT &&
                !(fifo_pop && fifo_out_data == osbp_pkg::HOST_ACK) &&
                tmr_q == CW'(TIMEOUT_CYC - 1)) begin
                vec_load <= 1'b1;
                vec_addr <= osbp_pkg::RESET_VEC;
            end else if (st_q == osbp_pkg::ST_RUN && irq_req) begin
                vec_load <= 1'b1;
                vec_addr <= osbp_pkg::INT_VEC;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fetch_pend_q <= 1'b0;
            fetch_valid  <= 1'b0;
            fetch_word   <= '1;
            fetch_nop    <= 1'b0;
            jump_target  <= '0;
        end else begin
            fetch_pend_q <= run_fetch;
            fetch_valid  <= fetch_pend_q;
            if (fetch_pend_q) begin
                fetch_word  <= {{(16-WORD_W){1'b1}}, mem_bus.rdata};
                fetch_nop   <= mem_bus.rdata == '0;
                jump_target <= (2 ** MEM_AW > osbp_pkg::PAGE_WORDS) ?
                    {page_select_latch_q,
                     mem_bus.rdata[osbp_pkg::JUMP_W-1:0]} :
                    {5'h00, mem_bus.rdata[osbp_pkg::JUMP_W-1:0]};
            end
        end
    end
endmodule : osbp_boot_top

/* File: sim/osbp_sva.sv */
`timescale 1ns/1ps
module osbp_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // device outputs
    input wire logic        tx_line,
    input wire logic        prog_voltage_enable_n,
    input wire logic        core_halt,
    input wire logic        boot_active,
    input wire logic        vec_load,
    input wire logic [15:0] vec_addr,
    // fetch
    input wire logic        fetch_req,
    input wire logic        table_write_instr,
    input wire logic        table_read_instr,
    input wire logic        fetch_valid,
    input wire logic [15:0] fetch_word,
    input wire logic        fetch_nop
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_vpp_halts_core: assert property (
        !prog_voltage_enable_n |-> core_halt) else $error("vpp on, core live");
    a_vec_values: assert property (
        vec_load |-> vec_addr == 16'h0000 || vec_addr == 16'h0004)
        else $error("bad vector");
    a_request_start: assert property (
        $rose(resetn) |-> ##[0:3] !tx_line) else $error("no request");
    a_fetch_lat: assert property (
        fetch_req && !core_halt && !boot_active && !table_write_instr
        && !table_read_instr |-> ##2 fetch_valid) else $error("fetch late");
    a_nop_decode: assert property (
        fetch_valid |-> fetch_nop == (fetch_word[13:0] == 14'h0000))
        else $error("nop decode");
    a_boot_halts: assert property (
        boot_active |-> core_halt) else $error("core runs in boot");
    a_pulse_min: assert property (
        $fell(prog_voltage_enable_n) |-> !prog_voltage_enable_n [*8])
        else $error("pulse short");
    a_boot_exit: assert property (
        $fell(boot_active) |-> $past(vec_load) && vec_addr == 16'h0000)
        else $error("no reset vector");
endmodule : osbp_sva
bind osbp_boot_top osbp_sva osbp_sva_i (.*);

/* File: sim/osbp_host.sv */
`timescale 1ns/1ps
module osbp_host #(parameter int BIT_CYC = 8) (
    // clock
    input  wire logic clk_sys,
    // serial link
    input  wire logic tx_line,
    output logic      rx_line
);
    logic [7:0] got[$];
    logic [7:0] b;
    initial rx_line = 1'b1;
    // 8N1, lsb first, line idles high
    task automatic send(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line = f[i];
            repeat (BIT_CYC) @(negedge clk_sys);
        end
    endtask : send
    // stop bit not waited, so back-to-back bytes are not missed
    always begin
        @(negedge tx_line);
        repeat (BIT_CYC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys);
            b[i] = tx_line;
        end
        got.push_back(b);
    end
endmodule : osbp_host

/* File: sim/osbp_boot_top_tb_top.sv */
`timescale 1ns/1ps
module osbp_boot_top_tb_top;
    logic clk_sys, resetn, rx_line, tx_line, vpp_n, halt, vl, irq, tw;
    logic tr, lw, lr, pw, freq, fv, fnop, boot, perr, pgw, ovr;
    logic [15:0] va, wd, lrd, fa, fw, a, d, jt;
    logic [4:0] pgd;
    logic [13:0] mdl [4] = '{4{14'h3FFF}};
    logic [31:0] lfsr = 32'h6010EED6;
    int n_fail = 0, tests_run = 0, m;
    osbp_boot_top #(.TIMEOUT_CYC(200), .PULSE_CYC(20), .BIT_CYC(8))
    osbp_boot_top_i (.clk_sys, .resetn, .rx_line, .tx_line,
        .prog_voltage_enable_n(vpp_n), .core_halt(halt), .vec_load(vl),
        .vec_addr(va), .irq_req(irq), .table_write_instr(tw),
        .table_read_instr(tr), .latch_write_instr(lw),
        .latch_read_instr(lr), .ptr_write(pw), .core_wdata(wd),
        .latch_rdata(lrd), .page_write(pgw), .page_wdata(pgd),
        .fetch_req(freq), .fetch_addr(fa), .fetch_valid(fv),
        .fetch_word(fw), .fetch_nop(fnop), .jump_target(jt),
        .boot_active(boot), .prog_error(perr), .rx_overrun(ovr));
    osbp_host #(.BIT_CYC(8)) osbp_host_i (.clk_sys, .tx_line, .rx_line);
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction : rnd
    task automatic check(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic wait_on(ref logic s, input logic v);
        int k;
        for (k = 0; k < 5000 && s !== v; k++) @(negedge clk_sys);
        if (k == 5000) begin n_fail++; final_report; end
    endtask : wait_on
    task automatic get_byte(input logic [7:0] exp);
        int k;
        for (k = 0; k < 5000 && osbp_host_i.got.size() == 0; k++)
            @(negedge clk_sys);
        if (k == 5000) begin n_fail++; final_report; end
        check({8'h00, osbp_host_i.got.pop_front()}, {8'h00, exp});
    endtask : get_byte
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk_sys);
        s = 0;
    endtask : pulse
    task automatic do_reset;
        resetn = 0;
        repeat (6) @(negedge clk_sys);
        resetn = 1;
        osbp_host_i.got.delete();
    endtask : do_reset
    initial begin
        {resetn, irq, tw, tr, lw, lr, pw, freq, wd, fa, pgw, pgd} = '0;
        do_reset;
        get_byte(8'hA5);
        wait_on(vl, 1);
        check(va, 16'h0000);
        @(negedge clk_sys);
        check({15'h0, boot}, 16'h0000);
        $display("silent host test done");
        for (int i = 0; i < 4; i++) begin
            a = rnd() & 16'h0003;
            d = (i == 3) ? 16'h0000 : rnd();
            mdl[a[1:0]] &= d[13:0];
            pgd = 5'(rnd());
            pulse(pgw);
            wd = a; pulse(pw); wd = d; pulse(lw); pulse(tw);
            wait_on(halt, 1); wait_on(halt, 0);
            pulse(tr); wait_on(halt, 1); wait_on(halt, 0); pulse(lr);
            fa = a; freq = 1; @(negedge clk_sys); freq = 0; wait_on(fv, 1);
            check({2'b00, fw[13:0]}, {2'b00, mdl[a[1:0]]});
            check({2'b00, lrd[13:0]}, {2'b00, mdl[a[1:0]]});
            check({15'h0, fnop}, {15'h0, mdl[a[1:0]] == 14'h0});
            check(jt, {5'h00, mdl[a[1:0]][10:0]});
            if (i == 3) check({2'b00, fw[13:0]}, 16'h0000);
        end
        irq = 1; wait_on(vl, 1); irq = 0;
        check(va, 16'h0004);
        $display("core table test done");
        do_reset;
        get_byte(8'hA5);
        repeat (16) @(negedge clk_sys);
        osbp_host_i.send(8'h5A);
        a = rnd() & 16'h07FF;
        m = 'h3FFF;
        for (int j = 0; j < 3; j++) begin
            d = rnd();
            foreach (d[k]) if (j == 2) d[k] = m[k];
            osbp_host_i.send(a[15:8]); osbp_host_i.send(a[7:0]);
            osbp_host_i.send(d[15:8]); osbp_host_i.send(d[7:0]);
            get_byte(((m & d[13:0]) == d[13:0]) ? 8'h06 : 8'h15);
            check({15'h0, perr}, {15'h0, (m & d[13:0]) != d[13:0]});
            m = m & d[13:0];
        end
        check({15'h0, ovr}, 16'h0000);
        $display("serial program test done");
        final_report;
    end
endmodule : osbp_boot_top_tb_top
